/* mst_operator.sv */
// Operator model: front button, display menu and command bit writes
`timescale 1ns/100ps
module mst_operator (
    input wire logic sys_clk,
    output logic button,
    output logic menu_req,
    output logic cmd_bit_wr,
    output logic cmd_bit_wdata
);
    // -----------------------------------------------------------------
    // Idle levels
    // -----------------------------------------------------------------
    initial begin
        button = 1'b0;
        menu_req = 1'b0;
        cmd_bit_wr = 1'b0;
        cmd_bit_wdata = 1'b0;
    end

    // -----------------------------------------------------------------
    // Requests
    // -----------------------------------------------------------------
    // Menu and command bit take one shared path so both are exercised alike
    task automatic request(input bit by_menu);
        @(negedge sys_clk);
        menu_req = by_menu;
        cmd_bit_wr = !by_menu;
        cmd_bit_wdata = !by_menu;
        @(negedge sys_clk);
        menu_req = 1'b0;
        cmd_bit_wr = 1'b0;
        cmd_bit_wdata = 1'b0;
    endtask

    // Short press only: the three second figure is far beyond the run length
    task automatic press(input int cycles);
        @(negedge sys_clk);
        button = 1'b1;
        repeat (cycles) @(negedge sys_clk);
        button = 1'b0;
    endtask
endmodule

/* mst_pkg.sv */
// Constants and types for the motor controller self-test block
package mst_pkg;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned PRESS_MIN_S = 3;
    localparam int unsigned PRESS_MAX_S = 15;
    localparam int unsigned OFF_LIMIT_MIN = 30;
    localparam longint unsigned PRESS_MIN_CYC = longint'(PRESS_MIN_S) * CLK_HZ;
    localparam longint unsigned PRESS_MAX_CYC = longint'(PRESS_MAX_S) * CLK_HZ;
    localparam longint unsigned OFF_LIMIT_S = longint'(OFF_LIMIT_MIN) * 60;
    localparam int unsigned STEP_CYC = 4;
    localparam int unsigned PRESS_W = 32;
    localparam int unsigned STEP_W = 8;
    // -----------------------------------------------------------------
    // Widths, positions and reset values
    // -----------------------------------------------------------------
    localparam int unsigned TIME_W = 32;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned HIST_N = 5;
    localparam int unsigned MEAS_W = 32;
    localparam int unsigned N_LED = 5;
    localparam int unsigned N_RELAY = 4;
    localparam int unsigned N_TRIP = 5;
    // LED positions
    localparam int unsigned LED_OPLINK = 0;
    localparam int unsigned LED_POWER = 1;
    localparam int unsigned LED_ALARM = 2;
    localparam int unsigned LED_FALLBACK = 3;
    localparam int unsigned LED_CTLLINK = 4;
    // Trip type positions
    localparam int unsigned TRIP_MINOR = 0;
    localparam int unsigned TRIP_SELFTEST = 1;
    localparam int unsigned TRIP_THERMAL = 2;
    localparam int unsigned TRIP_PHASE = 3;
    localparam int unsigned TRIP_OTHER = 4;
    localparam logic [4:0] LED_RST = 5'h00;
    localparam logic [3:0] RELAY_OPEN = 4'h0;
    localparam logic [31:0] TIME_RST = 32'h0000_0000;
    // Phase sequence encoding: 0 = ABC, 1 = ACB
    localparam logic PHASE_ABC = 1'b0;

    typedef enum logic [3:0] {
        MST_IDLE, MST_WDOG, MST_RAM, MST_THERM, MST_EXP, MST_COMM,
        MST_LED_OFF, MST_LED_SEQ, MST_RELAY, MST_HOLD, MST_OVLD
    } mst_state_e;
endpackage

/* mst_top.sv */
// Self-test sequencer with trip bookkeeping and clock hold-over
`timescale 1ns/100ps
module mst_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic button,
    input wire logic menu_req,
    input wire logic cmd_bit_wr,
    input wire logic cmd_bit_wdata,
    input wire logic selftest_enable,
    input wire logic motor_running,
    input wire logic current_seen,
    input wire logic expansion_present,
    input wire logic wdog_ok,
    input wire logic ram_ok,
    input wire logic therm_ok,
    input wire logic exp_ok,
    input wire logic comm_ok,
    input wire logic phase_cfg,
    input wire logic phase_meas,
    input wire logic phase_valid,
    input wire logic other_trip,
    input wire logic trip_reset,
    input wire logic second_tick,
    input wire logic time_wr,
    input wire logic [31:0] time_wdata,
    input wire logic power_lost,
    input wire logic power_back,
    input wire logic [31:0] off_seconds,
    input wire logic [31:0] measure,
    input wire logic [2:0] hist_sel,
    output logic [4:0] led,
    output logic [3:0] relay_closed_mask,
    output logic display_selftest,
    output logic cmd_bit,
    output logic [4:0] trip_active,
    output logic [31:0] date_time,
    output logic [31:0] trip_stamp,
    output logic [15:0] trip_count,
    output logic [31:0] hist_time,
    output logic [31:0] hist_meas
);
    // -----------------------------------------------------------------
    // Button press timing
    // -----------------------------------------------------------------
    logic [31:0] press_cnt;
    logic button_q;
    logic btn_req;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            press_cnt <= 32'h0000_0000;
            button_q <= 1'b0;
            btn_req <= 1'b0;
        end else begin
            button_q <= button;
            btn_req <= 1'b0;
            if (button) begin
                if (press_cnt <= 32'(mst_pkg::PRESS_MAX_CYC))
                    press_cnt <= press_cnt + 32'h0000_0001;
            end else begin
                press_cnt <= 32'h0000_0000;
            end
            // Start on release so a press held past the window is rejected
            if (button_q && !button && press_cnt > 32'(mst_pkg::PRESS_MIN_CYC)
                && press_cnt <= 32'(mst_pkg::PRESS_MAX_CYC))
                btn_req <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------
    mst_pkg::mst_state_e state;
    logic [7:0] step_cnt;
    logic [2:0] led_idx;
    logic any_trip;
    logic request;
    logic step_done;
    logic hold_release;
    assign any_trip = |trip_active;
    assign request = btn_req | menu_req | (cmd_bit_wr & cmd_bit_wdata);
    assign step_done = step_cnt == 8'(mst_pkg::STEP_CYC - 1);
    assign hold_release = trip_reset | btn_req | (button && !button_q);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= mst_pkg::MST_IDLE;
            step_cnt <= 8'h00;
            led_idx <= 3'h0;
        end else begin
            step_cnt <= step_done ? 8'h00 : step_cnt + 8'h01;
            unique case (state)
                mst_pkg::MST_IDLE: begin
                    step_cnt <= 8'h00;
                    if (request && !any_trip && selftest_enable)
                        state <= motor_running ? mst_pkg::MST_OVLD : mst_pkg::MST_WDOG;
                end
                mst_pkg::MST_OVLD: state <= mst_pkg::MST_IDLE;
                mst_pkg::MST_WDOG: if (step_done) state <= mst_pkg::MST_RAM;
                mst_pkg::MST_RAM: if (step_done) state <= mst_pkg::MST_THERM;
                mst_pkg::MST_THERM: if (step_done)
                    state <= expansion_present ? mst_pkg::MST_EXP : mst_pkg::MST_COMM;
                mst_pkg::MST_EXP: if (step_done) state <= mst_pkg::MST_COMM;
                mst_pkg::MST_COMM: if (step_done) state <= mst_pkg::MST_LED_OFF;
                mst_pkg::MST_LED_OFF: if (step_done) begin
                    state <= mst_pkg::MST_LED_SEQ;
                    led_idx <= 3'h0;
                end
                mst_pkg::MST_LED_SEQ: if (step_done) begin
                    if (led_idx == 3'h3)
                        state <= mst_pkg::MST_RELAY;
                    led_idx <= led_idx + 3'h1;
                end
                mst_pkg::MST_RELAY: if (step_done)
                    state <= (any_trip || !comm_ok) ? mst_pkg::MST_IDLE : mst_pkg::MST_HOLD;
                mst_pkg::MST_HOLD: if (hold_release) state <= mst_pkg::MST_IDLE;
            endcase
            // Motor current or a failed check ends the test early
            if (state != mst_pkg::MST_IDLE && state != mst_pkg::MST_HOLD && any_trip)
                state <= mst_pkg::MST_IDLE;
        end
    end

    logic testing;
    assign testing = state != mst_pkg::MST_IDLE && state != mst_pkg::MST_HOLD
                     && state != mst_pkg::MST_OVLD;

    // -----------------------------------------------------------------
    // LEDs, relays, display and command bit
    // -----------------------------------------------------------------
    logic [4:0] led_seq;
    always_comb begin
        unique case (led_idx)
            3'h0: led_seq = 5'h01 << mst_pkg::LED_OPLINK;
            3'h1: led_seq = 5'h01 << mst_pkg::LED_POWER;
            3'h2: led_seq = 5'h01 << mst_pkg::LED_FALLBACK;
            default: led_seq = 5'h01 << mst_pkg::LED_CTLLINK;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            led <= mst_pkg::LED_RST;
            relay_closed_mask <= mst_pkg::RELAY_OPEN;
            display_selftest <= 1'b0;
        end else begin
            if (state == mst_pkg::MST_LED_OFF)
                led <= 5'h00;
            else if (state == mst_pkg::MST_LED_SEQ)
                led <= led_seq;
            else if (testing || state == mst_pkg::MST_HOLD)
                led <= 5'h1f;
            else
                led <= 5'h01 << mst_pkg::LED_POWER;
            // Relays stay open through the whole test and hold phase
            relay_closed_mask <= (testing || state == mst_pkg::MST_HOLD)
                ? mst_pkg::RELAY_OPEN : 4'hf;
            display_selftest <= testing;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            cmd_bit <= 1'b0;
        else
            cmd_bit <= testing || (state == mst_pkg::MST_IDLE && request
                && !any_trip && selftest_enable);
    end

    // -----------------------------------------------------------------
    // Trips
    // -----------------------------------------------------------------
    logic [4:0] trip_set;
    logic check_fail;
    always_comb begin
        check_fail = step_done && ((state == mst_pkg::MST_WDOG && !wdog_ok)
            || (state == mst_pkg::MST_RAM && !ram_ok)
            || (state == mst_pkg::MST_THERM && !therm_ok)
            || (state == mst_pkg::MST_EXP && !exp_ok)
            || (state == mst_pkg::MST_COMM && !comm_ok));
        trip_set = 5'h00;
        trip_set[mst_pkg::TRIP_MINOR] = check_fail;
        trip_set[mst_pkg::TRIP_SELFTEST] = testing && current_seen;
        trip_set[mst_pkg::TRIP_THERMAL] = state == mst_pkg::MST_OVLD;
        trip_set[mst_pkg::TRIP_PHASE] = phase_valid && (phase_meas != phase_cfg);
        trip_set[mst_pkg::TRIP_OTHER] = other_trip;
    end

    // Set wins over a reset arriving in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            trip_active <= 5'h00;
        else
            trip_active <= (trip_reset ? 5'h00 : trip_active) | trip_set;
    end

    // -----------------------------------------------------------------
    // Internal clock and power-loss hold-over
    // -----------------------------------------------------------------
    logic [31:0] loss_time;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            date_time <= mst_pkg::TIME_RST;
            loss_time <= mst_pkg::TIME_RST;
        end else begin
            if (power_lost)
                loss_time <= date_time;
            if (time_wr)
                date_time <= time_wdata;
            else if (power_back) begin
                if (off_seconds > 32'(mst_pkg::OFF_LIMIT_S))
                    date_time <= loss_time;
                else
                    date_time <= loss_time + off_seconds;
            end else if (second_tick)
                date_time <= date_time + 32'h0000_0001;
        end
    end

    // -----------------------------------------------------------------
    // Trip stamp, counters and history
    // -----------------------------------------------------------------
    logic [15:0] counts [5];
    logic [31:0] h_time [5];
    logic [31:0] h_meas [5];
    logic [2:0] h_wp;
    logic [4:0] new_trip;
    assign new_trip = trip_set & ~trip_active;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            trip_stamp <= mst_pkg::TIME_RST;
            h_wp <= 3'h0;
            for (int i = 0; i < 5; i++) begin
                counts[i] <= 16'h0000;
                h_time[i] <= mst_pkg::TIME_RST;
                h_meas[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < 5; i++)
                if (new_trip[i])
                    counts[i] <= counts[i] + 16'h0001;
            if (|new_trip) begin
                trip_stamp <= date_time;
                h_time[h_wp] <= date_time;
                h_meas[h_wp] <= measure;
                h_wp <= (h_wp == 3'h4) ? 3'h0 : h_wp + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            trip_count <= 16'h0000;
            hist_time <= 32'h0000_0000;
            hist_meas <= 32'h0000_0000;
        end else begin
            trip_count <= (hist_sel < 3'h5) ? counts[hist_sel] : 16'h0000;
            hist_time <= (hist_sel < 3'h5) ? h_time[hist_sel] : 32'h0000_0000;
            hist_meas <= (hist_sel < 3'h5) ? h_meas[hist_sel] : 32'h0000_0000;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    property p_accept;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == mst_pkg::MST_IDLE && request && !any_trip && selftest_enable && !motor_running)
            |=> state == mst_pkg::MST_WDOG ##1 cmd_bit;
    endproperty
    a_accept: assert property (p_accept) else $error("Self test not started");

    property p_refuse;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == mst_pkg::MST_IDLE && (any_trip || !selftest_enable)) |=> state == mst_pkg::MST_IDLE;
    endproperty
    a_refuse: assert property (p_refuse) else $error("Test started while blocked");

    property p_relay;
        @(posedge sys_clk) disable iff (!rst_b)
        testing |=> relay_closed_mask == 4'h0;
    endproperty
    a_relay: assert property (p_relay) else $error("Relay closed in test");

    property p_display;
        @(posedge sys_clk) disable iff (!rst_b)
        testing |=> display_selftest && cmd_bit;
    endproperty
    a_display: assert property (p_display) else $error("Display or command bit low");

    property p_current;
        @(posedge sys_clk) disable iff (!rst_b)
        (testing && current_seen) |=> trip_active[mst_pkg::TRIP_SELFTEST] ##1 state == mst_pkg::MST_IDLE;
    endproperty
    a_current: assert property (p_current) else $error("No self-test trip");

    property p_thermal;
        @(posedge sys_clk) disable iff (!rst_b)
        state == mst_pkg::MST_OVLD |=> trip_active[mst_pkg::TRIP_THERMAL];
    endproperty
    a_thermal: assert property (p_thermal) else $error("No thermal trip");

    property p_phase;
        @(posedge sys_clk) disable iff (!rst_b)
        (phase_valid && phase_meas != phase_cfg) |=> trip_active[mst_pkg::TRIP_PHASE];
    endproperty
    a_phase: assert property (p_phase) else $error("No phase trip");

    property p_stamp;
        @(posedge sys_clk) disable iff (!rst_b)
        (|new_trip) |=> trip_stamp == $past(date_time);
    endproperty
    a_stamp: assert property (p_stamp) else $error("Trip stamp wrong");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == mst_pkg::MST_HOLD && !hold_release) |=> led == 5'h1f && relay_closed_mask == 4'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("Hold state outputs wrong");
endmodule

/* tb_top.sv */
// Testbench for the motor controller self-test block
`timescale 1ns/100ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic button, menu_req, cmd_bit_wr, cmd_bit_wdata;
    logic selftest_enable = 1'b1, motor_running = 1'b0, current_seen = 1'b0, expansion_present = 1'b0;
    logic [4:0] ok = 5'h1f;
    logic phase_cfg = 1'b0, phase_meas = 1'b0, phase_valid = 1'b0, other_trip = 1'b0, trip_reset = 1'b0;
    logic second_tick = 1'b0, time_wr = 1'b0, power_lost = 1'b0, power_back = 1'b0;
    logic [31:0] time_wdata = 32'h1234_5678, off_seconds = 32'h0000_0000, measure = 32'h00c0_0ffe;
    logic [2:0] hist_sel = 3'h0;
    logic [4:0] led, trip_active;
    logic [3:0] relay_closed_mask;
    logic display_selftest, cmd_bit;
    logic [31:0] date_time, trip_stamp, hist_time, hist_meas;
    logic [15:0] trip_count;
    int miscompares = 0;
    int checked = 0;
    logic [4:0] seen_q[$];
    int i, k;

    always #2.5 sys_clk = ~sys_clk;

    mst_operator op (.sys_clk(sys_clk), .button(button), .menu_req(menu_req), .cmd_bit_wr(cmd_bit_wr),
        .cmd_bit_wdata(cmd_bit_wdata));
    mst_top uut (.wdog_ok(ok[0]), .ram_ok(ok[1]), .therm_ok(ok[2]), .exp_ok(ok[3]), .comm_ok(ok[4]), .*);

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Bounded wait on the command bit, logging every LED change on the way
    task automatic wait_cmd(input logic v);
        int n;
        for (n = 0; n < 400 && cmd_bit !== v; n++) begin
            @(negedge sys_clk);
            if (seen_q.size() == 0 || led !== seen_q[$]) seen_q.push_back(led);
            if (cmd_bit === 1'b1) check("display", display_selftest, 32'h1);
        end
        if (cmd_bit !== v) begin
            miscompares++;
            end_of_test();
        end
    endtask

    task automatic pulse(input int which);
        @(negedge sys_clk);
        case (which)
            0: trip_reset = 1'b1;
            1: time_wr = 1'b1;
            2: power_lost = 1'b1;
            3: power_back = 1'b1;
            default: second_tick = 1'b1;
        endcase
        @(negedge sys_clk);
        {trip_reset, time_wr, power_lost, power_back, second_tick} = 5'h00;
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    initial begin
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        check("cmd_rst", cmd_bit, 32'h0);
        pulse(1);
        // Clean test from the menu; a failing expansion check must not matter when absent
        ok = 5'h17;
        op.request(1'b1);
        wait_cmd(1'b1);
        // Relays and LEDs follow the state one edge after the command bit rises
        @(negedge sys_clk);
        check("relay_run", relay_closed_mask, 32'h0);
        check("led_run", led, 32'h1f);
        seen_q.delete();
        wait_cmd(1'b0);
        for (i = 0; i < seen_q.size() && seen_q[i] !== 5'h00; i++) begin
        end
        check("led_seq0", seen_q[i + 1], 32'h1 << mst_pkg::LED_OPLINK);
        check("led_seq1", seen_q[i + 2], 32'h1 << mst_pkg::LED_POWER);
        check("led_seq2", seen_q[i + 3], 32'h1 << mst_pkg::LED_FALLBACK);
        check("led_seq3", seen_q[i + 4], 32'h1 << mst_pkg::LED_CTLLINK);
        repeat (20) @(negedge sys_clk);
        check("led_hold", led, 32'h1f);
        check("relay_hold", relay_closed_mask, 32'h0);
        check("trip_clean", trip_active, 32'h0);
        op.press(50);
        repeat (30) @(negedge sys_clk);
        check("short_press", cmd_bit, 32'h0);
        check("relay_free", relay_closed_mask, 32'hf);
        // Each check fails once, with the expansion module attached
        expansion_present = 1'b1;
        for (k = 0; k < 5; k++) begin
            ok = 5'h1f ^ (5'h01 << k);
            time_wdata = 32'h1234_5678 + 32'(k);
            measure = 32'h00c0_0ff0 + 32'(k);
            pulse(1);
            op.request(1'b0);
            wait_cmd(1'b1);
            wait_cmd(1'b0);
            check("minor", trip_active, 32'h1 << mst_pkg::TRIP_MINOR);
            check("stamp", trip_stamp, 32'h1234_5678 + 32'(k));
            pulse(0);
        end
        ok = 5'h1f;
        hist_sel = 3'(mst_pkg::TRIP_MINOR);
        repeat (2) @(negedge sys_clk);
        check("count", trip_count, 32'h5);
        hist_sel = 3'h4;
        repeat (2) @(negedge sys_clk);
        check("hist_time", hist_time, 32'h1234_567c);
        check("hist_meas", hist_meas, 32'h00c0_0ff4);
        hist_sel = 3'h0;
        repeat (2) @(negedge sys_clk);
        check("hist_time0", hist_time, 32'h1234_5678);
        check("hist_meas0", hist_meas, 32'h00c0_0ff0);
        hist_sel = 3'h5;
        repeat (2) @(negedge sys_clk);
        check("hist_none", hist_time, 32'h0);
        // Refused with a trip standing, then refused while disabled
        other_trip = 1'b1;
        @(negedge sys_clk);
        other_trip = 1'b0;
        for (k = 0; k < 2; k++) begin
            op.request(1'b1);
            repeat (20) @(negedge sys_clk);
            check("refused", cmd_bit, 32'h0);
            pulse(0);
            selftest_enable = 1'b0;
        end
        selftest_enable = 1'b1;
        // Current appears in mid-test
        op.request(1'b0);
        wait_cmd(1'b1);
        current_seen = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("st_trip", trip_active[mst_pkg::TRIP_SELFTEST], 32'h1);
        current_seen = 1'b0;
        wait_cmd(1'b0);
        pulse(0);
        // Motor running turns the test into a thermal overload
        motor_running = 1'b1;
        op.request(1'b1);
        repeat (4) @(negedge sys_clk);
        check("thermal", trip_active[mst_pkg::TRIP_THERMAL], 32'h1);
        motor_running = 1'b0;
        wait_cmd(1'b0);
        pulse(0);
        // Phase order against both configured sequences
        phase_valid = 1'b1;
        for (k = 0; k < 4; k++) begin
            {phase_cfg, phase_meas} = 2'(k);
            // Clear after the new setting is applied: a live mismatch wins over the clear
            pulse(0);
            repeat (2) @(negedge sys_clk);
            check("phase", trip_active[mst_pkg::TRIP_PHASE], 32'(phase_cfg ^ phase_meas));
        end
        phase_valid = 1'b0;
        // Clock across a short and a long outage
        pulse(4);
        check("tick", date_time, 32'h1234_567d);
        pulse(2);
        off_seconds = 32'h0000_0708;
        pulse(3);
        check("short_off", date_time, 32'h1234_5d85);
        pulse(2);
        off_seconds = 32'h0000_0709;
        pulse(3);
        check("long_off", date_time, 32'h1234_5d85);
        end_of_test();
    end
endmodule
